// File: verilog/sdc_pkg.sv
// Purpose: Shared constants for the sigma-delta converter control port
// Assumes: 25 MHz master clock; 8-bit command, up to 24-bit registers
// Notes:   Contract
package sdc_pkg;

  // Clock and timing
  localparam int CLK_HZ        = 25_000_000; // Master clock rate
  localparam int FS_FULL_HZ    = 614_400;    // Full-mode modulator rate
  localparam int ODR_MAX_HZ    = 19_200;     // Output word rate cap
  localparam int FULL_DIV      = CLK_HZ / FS_FULL_HZ;
  localparam int MIN_WORD_CYC  = (CLK_HZ + ODR_MAX_HZ - 1) / ODR_MAX_HZ;
  localparam int MID_SHIFT     = 2;          // Divide by 4
  localparam int LOW_SHIFT     = 3;          // Divide by 8
  localparam int SETTLE_S3_MS  = 60;         // Third_order_sinc at 50 sps
  localparam int SETTLE_PF_MS  = 40;         // Post filter at 25 sps
  localparam int SETTLE_S3_CYC = SETTLE_S3_MS * (CLK_HZ / 1000);
  localparam int SETTLE_PF_CYC = SETTLE_PF_MS * (CLK_HZ / 1000);

  // Register addresses (6-bit field of the command byte)
  localparam logic [5:0] A_STAT = 6'h00;
  localparam logic [5:0] A_CTRL = 6'h01;
  localparam logic [5:0] A_DATA = 6'h02;
  localparam logic [5:0] A_DIAG = 6'h03;
  localparam logic [5:0] A_FILT = 6'h04;
  localparam logic [5:0] A_GAIN = 6'h05;

  // Command byte fields
  localparam int CMD_WEN_BIT = 7;            // Must be zero
  localparam int CMD_RD_BIT  = 6;            // One for read

  // Control register fields
  localparam int CTL_PM_LSB  = 0;            // Power mode [1:0]
  localparam int CTL_CM_LSB  = 2;            // Conversion mode [3:2]
  localparam int CTL_EXC_BIT = 4;            // Excitation enable
  localparam int CTL_BIP_BIT = 5;            // Bipolar coding

  // Filter register fields
  localparam int FLT_TY_LSB  = 21;           // Filter type [23:21]
  localparam int FLT_PS_LSB  = 18;           // Post filter select [20:18]
  localparam int FLT_FS_W    = 11;           // Rate code [10:0]
  localparam logic [10:0] FS_50SPS  = 11'h180;
  localparam logic [2:0]  PS_25SPS  = 3'h2;

  // Diagnostic enable bits
  localparam int DG_REGMON   = 0;
  localparam int DG_SERCHK   = 1;

  // Status register bits
  localparam int ST_RDYN     = 7;
  localparam int ST_SERR     = 6;
  localparam int ST_RERR     = 5;

  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [23:0] FILT_RST = 24'h000180;
  localparam logic [15:0] DIAG_RST = 16'h0000;
  localparam logic [23:0] GAIN_RST = 24'h500000;
  localparam logic [23:0] MID_CODE = 24'h800000; // Bipolar zero

  typedef enum logic [1:0] {
    PM_LOW  = 2'b00,
    PM_MID  = 2'b01,
    PM_FULL = 2'b10
  } sdc_pm_e;

  typedef enum logic [1:0] {
    CM_CONT  = 2'b00,
    CM_SINGLE = 2'b01,
    CM_STBY  = 2'b10,
    CM_IDLE  = 2'b11
  } sdc_cm_e;

  typedef enum logic [2:0] {
    FT_FOURTH_ORDER_SINC     = 3'b000,
    FT_THIRD_ORDER_SINC     = 3'b001,
    FT_FOURTH_ORDER_SINC_AVG = 3'b010,
    FT_THIRD_ORDER_SINC_AVG = 3'b011,
    FT_POST      = 3'b100
  } sdc_ft_e;

endpackage

// File: verilog/sdc_tick.sv
// Purpose: Programmable period tick generator
// Assumes: period of at least 1 cycle
// Notes:   Restarts the count whenever run is low
`timescale 1ns/100ps
module sdc_tick #(
  parameter int W = 24
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  // Control
  input  wire logic         run,
  input  wire logic [W-1:0] period,
  // Output
  output logic              tick
);

  logic [W-1:0] cnt_r;   // Cycles elapsed in this period
  logic [W-1:0] cnt_nxt;
  logic         tick_nxt;

  // Count up, pulse on the last cycle of each period
  always_comb begin
    cnt_nxt  = cnt_r + 1'b1;
    tick_nxt = 1'b0;
    if (!run) begin
      cnt_nxt = '0;
    end else if (cnt_r >= period - 1'b1) begin
      cnt_nxt  = '0;
      tick_nxt = 1'b1;
    end
  end

  // Register only
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick  <= tick_nxt;
    end
  end

endmodule // sdc_tick

// File: verilog/sdc_ctrl.sv
// Purpose: Serial control port, settings and conversion sequencing
// Assumes: Serial pins sampled synchronously to ref_clk
// Notes:   Mode 3 style port: data in on rising, out on falling
`timescale 1ns/100ps
module sdc_ctrl
  import sdc_pkg::*;
#(
  parameter int  SETTLE_S3   = SETTLE_S3_CYC, // Third_order_sinc 50 sps settling
  parameter int  SETTLE_PF   = SETTLE_PF_CYC, // Post 25 sps settling
  parameter bit  IMPROVED_REV = 1'b1           // Improved silicon
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Serial port
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe,
  // Modulator side
  input  wire logic [23:0] adc_in,      // Signed raw result
  input  wire logic        gain_upset,  // Clock-skew upset event
  output logic             mod_sample,
  output logic [23:0]      conv_data,
  output logic             conv_valid,
  // Status and enables
  output logic [1:0]       pwr_mode,
  output logic             excite_on,
  output logic [1:0]       diag_en,
  output logic             reg_err,
  output logic             ser_err
);

  typedef enum logic [1:0] {
    S_CMD = 2'b00,
    S_WR  = 2'b01,
    S_RD  = 2'b10
  } sdc_ser_e;

  typedef enum logic [1:0] {
    C_IDLE   = 2'b00,
    C_SETTLE = 2'b01,
    C_RUN    = 2'b10
  } sdc_cv_e;

  // Serial group
  sdc_ser_e    ser_r, ser_nxt;
  logic        sclk_r;                 // Previous serial clock level
  logic [4:0]  bit_r, bit_nxt;         // Bits taken in this phase
  logic [4:0]  nb_r, nb_nxt;           // Bits in the data phase
  logic [5:0]  adr_r, adr_nxt;         // Selected register
  logic [22:0] sh_in_r, sh_in_nxt;
  logic [23:0] sh_out_r, sh_out_nxt;
  logic        wr_go, rd_dat, rd_st, bad_cmd;
  logic [23:0] wr_word;
  logic        sclk_rise, sclk_fall;

  // Config group
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [23:0] filt_r, filt_nxt;
  logic [15:0] diag_r, diag_nxt;
  logic [23:0] gain_r, gain_nxt;
  logic [23:0] csum_r, csum_nxt;        // Fold of settings last written
  logic        rerr_r, rerr_nxt;
  logic        serr_r, serr_nxt;
  logic        restart;                // Settling must start over
  logic        restart_r;              // Restart seen one cycle ago

  // Conversion group
  sdc_cv_e     cv_r, cv_nxt;
  logic [23:0] set_r, set_nxt;         // Settling countdown
  logic [23:0] data_r, data_nxt;
  logic        rdyn_r, rdyn_nxt;       // Low when a word is waiting
  logic        val_nxt;
  logic        sdo_nxt;
  logic [23:0] samp_div, word_iv, settle_ld;
  logic        word_tick, mod_tick;
  logic [23:0] csum_now;

  assign sclk_rise = sclk & ~sclk_r;
  assign sclk_fall = ~sclk & sclk_r;
  assign wr_word   = {sh_in_r, sdi};

  // Register width in bits; zero marks an unmapped address
  function automatic logic [4:0] reg_bits(input logic [5:0] a);
    case (a)
      A_STAT:           reg_bits = 5'd8;
      A_CTRL, A_DIAG:   reg_bits = 5'd16;
      A_DATA, A_FILT,
      A_GAIN:           reg_bits = 5'd24;
      default:          reg_bits = 5'd0;
    endcase
  endfunction

  // Read value, left aligned so the MSB leaves first
  function automatic logic [23:0] rd_val(input logic [5:0] a);
    case (a)
      A_STAT:  rd_val = {rdyn_r, serr_r, rerr_r, 3'h0, ctrl_r[1:0], 16'h0};
      A_CTRL:  rd_val = {ctrl_r, 8'h00};
      A_DATA:  rd_val = data_r;
      A_DIAG:  rd_val = {diag_r, 8'h00};
      A_FILT:  rd_val = filt_r;
      A_GAIN:  rd_val = gain_r;
      default: rd_val = 24'h000000;
    endcase
  endfunction

  // Serial port next state
  always_comb begin
    ser_nxt    = ser_r;
    bit_nxt    = bit_r;
    nb_nxt     = nb_r;
    adr_nxt    = adr_r;
    sh_in_nxt  = sh_in_r;
    sh_out_nxt = sh_out_r;
    wr_go      = 1'b0;
    rd_dat     = 1'b0;
    rd_st      = 1'b0;
    bad_cmd    = 1'b0;
    if (cs_n) begin
      // Abandon any partial transfer, wait for a command
      ser_nxt = S_CMD;
      bit_nxt = 5'd0;
    end else if (sclk_rise) begin
      // Only clock edges advance, so byte pauses are harmless
      sh_in_nxt = wr_word[22:0];
      bit_nxt   = bit_r + 5'd1;
      unique case (ser_r)
        S_CMD: if (bit_r == 5'd7) begin
          // First byte after select is the command
          bit_nxt = 5'd0;
          adr_nxt = wr_word[5:0];
          nb_nxt  = reg_bits(wr_word[5:0]);
          if (wr_word[CMD_WEN_BIT] || nb_nxt == 5'd0) begin
            bad_cmd = 1'b1;
          end else if (wr_word[CMD_RD_BIT]) begin
            ser_nxt    = S_RD;
            sh_out_nxt = rd_val(wr_word[5:0]);
          end else begin
            ser_nxt = S_WR;
          end
        end
        S_WR: if (bit_r == nb_r - 5'd1) begin
          // Whole word in: only now may a write change settings
          wr_go   = 1'b1;
          ser_nxt = S_CMD;
          bit_nxt = 5'd0;
        end
        S_RD: if (bit_r == nb_r - 5'd1) begin
          rd_dat  = (adr_r == A_DATA);
          rd_st   = (adr_r == A_STAT);
          ser_nxt = S_CMD;
          bit_nxt = 5'd0;
        end
      endcase
    end else if (sclk_fall && ser_r == S_RD && bit_r != 5'd0) begin
      // First bit already shown; later falling edges shift
      sh_out_nxt = {sh_out_r[22:0], 1'b0};
    end
    // Output shows data when reading, else the ready flag
    sdo_nxt = (ser_r == S_RD) ? sh_out_r[23] : rdyn_r;
  end

  // Serial port registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ser_r    <= S_CMD;
      sclk_r   <= 1'b1;
      bit_r    <= 5'd0;
      nb_r     <= 5'd0;
      adr_r    <= 6'h00;
      sh_in_r  <= 23'h000000;
      sh_out_r <= 24'h000000;
      sdo      <= 1'b1;
      sdo_oe   <= 1'b0;
    end else begin
      ser_r    <= ser_nxt;
      sclk_r   <= sclk;
      bit_r    <= bit_nxt;
      nb_r     <= nb_nxt;
      adr_r    <= adr_nxt;
      sh_in_r  <= sh_in_nxt;
      sh_out_r <= sh_out_nxt;
      sdo      <= sdo_nxt;
      sdo_oe   <= ~cs_n;
    end
  end

  // Fold of the settings guarded by register monitoring
  assign csum_now = filt_r ^ gain_r ^ {ctrl_r, diag_r[7:0]};

  // Settings next state
  always_comb begin
    ctrl_nxt = ctrl_r;
    filt_nxt = filt_r;
    diag_nxt = diag_r;
    gain_nxt = gain_r;
    restart  = 1'b0;
    if (wr_go) begin
      // Apply a finished write
      unique case (adr_r)
        A_CTRL: begin
          ctrl_nxt = wr_word[15:0];
          restart  = 1'b1;
        end
        A_FILT: begin
          filt_nxt = wr_word;
          restart  = 1'b1;
        end
        A_DIAG: diag_nxt = wr_word[15:0];
        A_GAIN: gain_nxt = wr_word;
        default: ;                         // Status, data: read only
      endcase
    end else if (gain_upset && !IMPROVED_REV) begin
      // Only the original silicon loses its gain setting
      gain_nxt = GAIN_RST;
    end
    csum_nxt = wr_go ? (filt_nxt ^ gain_nxt ^ {ctrl_nxt, diag_nxt[7:0]})
                     : csum_r;
    // Sticky errors: a new event beats a clearing read
    rerr_nxt = rerr_r & ~rd_st;
    if (diag_r[DG_REGMON] && csum_now != csum_r) begin
      rerr_nxt = 1'b1;
    end
    serr_nxt = serr_r & ~rd_st;
    if (diag_r[DG_SERCHK] && bad_cmd) begin
      serr_nxt = 1'b1;
    end
  end

  // Settings registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r  <= CTRL_RST;
      filt_r  <= FILT_RST;
      diag_r  <= DIAG_RST;
      gain_r  <= GAIN_RST;
      csum_r  <= FILT_RST ^ GAIN_RST ^ {CTRL_RST, DIAG_RST[7:0]};
      rerr_r  <= 1'b0;
      serr_r  <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      filt_r  <= filt_nxt;
      diag_r  <= diag_nxt;
      gain_r  <= gain_nxt;
      csum_r  <= csum_nxt;
      rerr_r  <= rerr_nxt;
      serr_r  <= serr_nxt;
    end
  end

  // Modulator period per power mode; codes 11 act as full
  always_comb begin
    unique case (ctrl_r[CTL_PM_LSB +: 2])
      PM_LOW:  samp_div = 24'(FULL_DIV << LOW_SHIFT);
      PM_MID:  samp_div = 24'(FULL_DIV << MID_SHIFT);
      default: samp_div = 24'(FULL_DIV);
    endcase
    // Word interval in clocks, never faster than the cap
    word_iv = 24'(filt_r[FLT_FS_W-1:0] * samp_div);
    if (word_iv < 24'(MIN_WORD_CYC)) begin
      word_iv = 24'(MIN_WORD_CYC);
    end
    // Settling time depends on the chosen filter
    unique case (filt_r[FLT_TY_LSB +: 3])
      FT_THIRD_ORDER_SINC: settle_ld = (filt_r[FLT_FS_W-1:0] == FS_50SPS)
                            ? 24'(SETTLE_S3) : 24'(word_iv * 3);
      FT_THIRD_ORDER_SINC_AVG: settle_ld = 24'(word_iv * 3);
      FT_POST:  settle_ld = (filt_r[FLT_PS_LSB +: 3] == PS_25SPS)
                            ? 24'(SETTLE_PF) : word_iv;
      default:  settle_ld = 24'(word_iv * 4);
    endcase
  end

  // Modulator sampling clock, running whenever converting
  sdc_tick #(.W(24)) u_mod (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .run     (cv_r != C_IDLE),
    .period  (samp_div),
    .tick    (mod_tick)
  );

  // Output word pacing after settling
  sdc_tick #(.W(24)) u_word (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .run     (cv_r == C_RUN && !restart),
    .period  (word_iv),
    .tick    (word_tick)
  );

  // Conversion sequencing, independent of chip select
  always_comb begin
    cv_nxt   = cv_r;
    set_nxt  = set_r;
    data_nxt = data_r;
    val_nxt  = 1'b0;
    rdyn_nxt = rdyn_r | rd_dat;
    if (restart || restart_r) begin
      // New control or filter settings, including power mode, resettle
      // Loaded again a cycle later: only then do the filter registers,
      // and so the settling count, reflect what was just written
      set_nxt = settle_ld;
      cv_nxt  = (ctrl_nxt[CTL_CM_LSB +: 2] == CM_CONT ||
                 ctrl_nxt[CTL_CM_LSB +: 2] == CM_SINGLE) ? C_SETTLE
                                                         : C_IDLE;
    end else begin
      unique case (cv_r)
        C_IDLE:   ;
        C_SETTLE: begin
          set_nxt = set_r - 24'h000001;
          if (set_r <= 24'h000001) begin
            val_nxt = 1'b1;
            cv_nxt  = (ctrl_r[CTL_CM_LSB +: 2] == CM_SINGLE) ? C_IDLE
                                                           : C_RUN;
          end
        end
        C_RUN:    val_nxt = word_tick;
      endcase
    end
    if (val_nxt) begin
      // Offset binary in bipolar, clamped straight binary else
      if (ctrl_r[CTL_BIP_BIT]) begin
        data_nxt = adc_in ^ MID_CODE;
      end else begin
        data_nxt = adc_in[23] ? 24'h000000 : {adc_in[22:0], 1'b0};
      end
      rdyn_nxt = 1'b0;
    end
  end

  // Conversion registers and plain status outputs
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cv_r       <= C_IDLE;
      restart_r  <= 1'b0;
      set_r      <= 24'h000000;
      data_r     <= 24'h000000;
      rdyn_r     <= 1'b1;
      conv_valid <= 1'b0;
      conv_data  <= 24'h000000;
      mod_sample <= 1'b0;
      pwr_mode   <= 2'b00;
      excite_on  <= 1'b0;
      diag_en    <= 2'b00;
      reg_err    <= 1'b0;
      ser_err    <= 1'b0;
    end else begin
      cv_r       <= cv_nxt;
      restart_r  <= restart;
      set_r      <= set_nxt;
      data_r     <= data_nxt;
      rdyn_r     <= rdyn_nxt;
      conv_valid <= val_nxt;
      conv_data  <= data_nxt;
      mod_sample <= mod_tick;
      pwr_mode   <= ctrl_r[CTL_PM_LSB +: 2];
      // Original silicon drops excitation in standby
      excite_on  <= ctrl_r[CTL_EXC_BIT] & (IMPROVED_REV ||
                    ctrl_r[CTL_CM_LSB +: 2] != CM_STBY);
      diag_en    <= diag_r[1:0];
      reg_err    <= rerr_r;
      ser_err    <= serr_r;
    end
  end

  // Checks, all on the one clock and quiet during reset
  default clocking chk_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_cmd_write;
    wr_go && (adr_r == A_CTRL || adr_r == A_FILT);
  endsequence
  // Final load lands in set_r two cycles after the restart, from the new settings
  sequence s_resettle;
    ##1 (cv_r == C_SETTLE || cv_r == C_IDLE) && set_r == $past(settle_ld);
  endsequence

  chk_cs_resets: assert property (
    cs_n |=> ser_r == S_CMD && bit_r == 5'd0)
    else $error("serial state not reset by chip select");
  chk_sdo_tristate: assert property (cs_n |=> !sdo_oe)
    else $error("output enabled while deselected");
  chk_mode_divide: assert property (
    ctrl_r[CTL_PM_LSB +: 2] == PM_MID |-> samp_div == 24'(4 * FULL_DIV))
    else $error("mid mode divide wrong");
  chk_word_cap: assert property (word_iv >= 24'(MIN_WORD_CYC))
    else $error("word rate above cap");
  chk_write_only: assert property ($changed(ctrl_r) |-> $past(wr_go))
    else $error("settings changed without finished write");
  chk_resettle: assert property (s_cmd_write |=> s_resettle)
    else $error("settling not restarted");
  chk_bipolar_code: assert property (
    val_nxt && ctrl_r[CTL_BIP_BIT] |=> conv_data == ($past(adc_in) ^ MID_CODE))
    else $error("bipolar coding wrong");
  chk_standby_exc: assert property (
    !IMPROVED_REV && ctrl_r[CTL_CM_LSB +: 2] == CM_STBY |=> !excite_on)
    else $error("excitation on in standby");
  chk_gain_kept: assert property (
    IMPROVED_REV && gain_upset && !wr_go |=> $stable(gain_r))
    else $error("gain register reverted");
  chk_diag_off: assert property (
    !diag_r[DG_SERCHK] && !serr_r |=> !serr_r)
    else $error("serial error set while check disabled");
  chk_single_done: assert property (
    cv_r == C_SETTLE && !restart |=> cv_r != C_IDLE || conv_valid)
    else $error("single conversion abandoned");

endmodule // sdc_ctrl

// File: verif/sdc_host.sv
// Purpose: Host model driving the converter serial control port
// Assumes: Pins change on the ref_clk falling edge only
// Notes:   Serial clock idles high and stands still between frames
`timescale 1ns/100ps
module sdc_host (
  // Clock
  input  wire logic ref_clk,
  // Serial port
  input  wire logic sdo,
  output logic      cs_n,
  output logic      sclk,
  output logic      sdi
);
  localparam int HALF = 6; // Cycles per sclk level, margin over 2

  // Idle: deselected, clock parked high
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    sdi  = 1'b0;
  end

  // One byte MSB first; sdo taken late in the low phase
  task automatic shift8(input logic [7:0] wd, output logic [7:0] rd);
    for (int i = 7; i >= 0; i--) begin
      @(negedge ref_clk);
      sclk <= 1'b0;
      sdi  <= wd[i];
      repeat (HALF) @(negedge ref_clk);
      rd[i] = sdo;
      sclk <= 1'b1;
      repeat (HALF - 1) @(negedge ref_clk);
    end
  endtask

  // Command byte then nb data bytes, gap cycles between bytes
  task automatic frame(input logic [7:0] cmd, input int nb,
                       input logic [23:0] wd, input int gap,
                       output logic [23:0] rd);
    logic [7:0] b;
    rd = 24'h0;
    @(negedge ref_clk);
    cs_n <= 1'b0;
    shift8(cmd, b);
    for (int k = nb - 1; k >= 0; k--) begin
      repeat (gap) @(negedge ref_clk);
      shift8(wd[8*k +: 8], b);
      rd = {rd[15:0], b};
    end
    repeat (HALF) @(negedge ref_clk);
    cs_n <= 1'b1;
    sdi  <= ~sdi; // Released line shows no stale data
  endtask
endmodule // sdc_host

// File: verif/sdc_ctrl_test.sv
// Purpose: Self-checking bench for the converter control port
// Assumes: Shortened settling counts; one host shared by two parts
// Notes:   rev[0] is original silicon, rev[1] the improved one
`timescale 1ns/100ps
module sdc_ctrl_test
  import sdc_pkg::*;
;
  localparam int S3 = 200; // Shortened third_order_sinc settling
  localparam int PF = 100; // Shortened post filter settling
  // Stimulus
  logic        ref_clk, rstn, cs_n, sclk, sdi, sel, gain_upset;
  logic [23:0] adc_in;
  // Per revision outputs
  logic        sdo [2], sdo_oe [2], mod_sample [2], conv_valid [2];
  logic        excite_on [2], reg_err [2], ser_err [2];
  logic [23:0] conv_data [2];
  logic [1:0]  pwr_mode [2], diag_en [2];
  int          failures = 0;
  int          checks = 0;

  // Both revisions see the same serial traffic
  for (genvar g = 0; g < 2; g++) begin : rev
    sdc_ctrl #(.SETTLE_S3(S3), .SETTLE_PF(PF), .IMPROVED_REV(g == 1))
      sdc_ctrl_inst (.ref_clk(ref_clk), .rstn(rstn), .cs_n(cs_n),
      .sclk(sclk), .sdi(sdi), .sdo(sdo[g]), .sdo_oe(sdo_oe[g]),
      .adc_in(adc_in), .gain_upset(gain_upset),
      .mod_sample(mod_sample[g]), .conv_data(conv_data[g]),
      .conv_valid(conv_valid[g]), .pwr_mode(pwr_mode[g]),
      .excite_on(excite_on[g]), .diag_en(diag_en[g]),
      .reg_err(reg_err[g]), .ser_err(ser_err[g]));
  end

  // Host reads whichever revision sel names
  sdc_host sdc_host_inst (.ref_clk(ref_clk), .sdo(sdo[sel]),
    .cs_n(cs_n), .sclk(sclk), .sdi(sdi));

  // 25 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic results;
    if (failures == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [23:0] e,
                     input logic [23:0] s);
    checks++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Cycle counts against a window
  task automatic chk_rng(input string nm, input int lo, input int hi,
                         input int s);
    checks++;
    if (s < lo || s > hi) begin
      failures++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, s);
    end
  endtask

  task automatic wr(input logic [5:0] a, input int nb, input logic [23:0] d);
    logic [23:0] r;
    sdc_host_inst.frame({2'b00, a}, nb, d, 0, r);
  endtask

  task automatic rd(input logic [5:0] a, input int nb,
                    output logic [23:0] r);
    sdc_host_inst.frame({2'b01, a}, nb, 24'h0, 0, r);
  endtask

  // Bounded wait for the next result of rev[1]
  task automatic wait_valid(output int n);
    n = 0;
    while (conv_valid[1] !== 1'b1 && n < 40000) begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  // Spacing of two modulator sample pulses
  task automatic gap(output int n);
    int k = 0;
    n = 0;
    while (mod_sample[1] !== 1'b1 && k < 999) begin
      @(negedge ref_clk);
      k++;
    end
    do begin
      @(negedge ref_clk);
      n++;
    end while (mod_sample[1] !== 1'b1 && n < 999);
  endtask

  task automatic t_reset;
    logic [23:0] r;
    chk("sdo_oe idle", 24'h0, 24'(sdo_oe[1]));
    rd(A_CTRL, 2, r);
    chk("ctrl reset", 24'(CTRL_RST), r);
    rd(A_FILT, 3, r);
    chk("filt reset", FILT_RST, r);
    rd(A_GAIN, 3, r);
    chk("gain reset", GAIN_RST, r);
  endtask

  // Each power mode and its sample spacing, then an aborted write
  task automatic t_power;
    int div [3] = '{FULL_DIV << LOW_SHIFT, FULL_DIV << MID_SHIFT, FULL_DIV};
    int n;
    logic [23:0] r;
    for (int i = 0; i < 3; i++) begin
      wr(A_CTRL, 2, 24'(i));
      chk("pwr_mode", 24'(i), 24'(pwr_mode[1]));
      gap(n);
      chk_rng("sample gap", div[i], div[i], n);
    end
    sdc_host_inst.frame(8'h01, 1, 24'h01, 0, r);
    chk("pwr_mode abort", 24'h2, 24'(pwr_mode[1]));
    wr(A_CTRL, 2, 24'h01);
    chk("pwr_mode after", 24'h1, 24'(pwr_mode[1]));
  endtask

  task automatic t_filter;
    logic [23:0] r;
    int n;
    for (int t = 0; t < 5; t++) begin
      wr(A_FILT, 3, {3'(t), 21'h180});
      rd(A_FILT, 3, r);
      chk("filt type", {3'(t), 21'h180}, r);
    end
    sdc_host_inst.frame(8'h04, 3, 24'h200180, 20, r);
    wait_valid(n);
    chk_rng("third_order_sinc settle", S3 - 12, S3 + 40, n);
    wr(A_FILT, 3, 24'h880180);
    wait_valid(n);
    chk_rng("post settle", PF - 12, PF + 40, n);
    wr(A_CTRL, 2, 24'h02);
    wait_valid(n);
    chk_rng("mode resettle", PF - 12, PF + 40, n);
  endtask

  // Bipolar then unipolar coding of raw values
  task automatic t_coding;
    logic [23:0] av [2] = '{24'h000100, 24'hffff00};
    logic [23:0] e;
    int n;
    for (int i = 0; i < 4; i++) begin
      adc_in = av[i % 2];
      e = (i < 2) ? adc_in ^ MID_CODE : (adc_in[23] ? 24'h0 : adc_in << 1);
      wr(A_CTRL, 2, (i < 2) ? 24'h22 : 24'h02);
      wait_valid(n);
      chk("code", e, conv_data[1]);
    end
    adc_in = 24'h0;
    wr(A_CTRL, 2, 24'h22);
    wait_valid(n);
    chk("bipolar zero", MID_CODE, conv_data[1]);
  endtask

  // Single conversion runs on while the port is busy
  task automatic t_single;
    logic [23:0] r;
    int n;
    wr(A_CTRL, 2, 24'h06);
    fork
      wait_valid(n);
      rd(A_STAT, 1, r);
      begin
        wait (cs_n === 1'b0);
        repeat (3) @(negedge ref_clk);
        chk("sdo_oe selected", 24'h1, 24'(sdo_oe[1]));
      end
    join
    chk_rng("single done", PF - 12, PF + 40, n);
    repeat (2) @(negedge ref_clk);
    chk("sdo_oe released", 24'h0, 24'(sdo_oe[1]));
  endtask

  task automatic t_rev;
    logic [23:0] r;
    wr(A_CTRL, 2, 24'h10);
    chk("excite rev0 run", 24'h1, 24'(excite_on[0]));
    wr(A_CTRL, 2, 24'h18);
    chk("excite rev0 stby", 24'h0, 24'(excite_on[0]));
    chk("excite rev1 stby", 24'h1, 24'(excite_on[1]));
    wr(A_GAIN, 3, 24'h123456);
    gain_upset = 1'b1;
    @(negedge ref_clk);
    gain_upset = 1'b0;
    sel = 1'b0;
    rd(A_GAIN, 3, r);
    chk("gain rev0", GAIN_RST, r);
    sel = 1'b1;
    rd(A_GAIN, 3, r);
    chk("gain rev1", 24'h123456, r);
  endtask

  task automatic t_diag;
    logic [23:0] r;
    sdc_host_inst.frame(8'h80, 0, 24'h0, 0, r);
    chk("ser_err off", 24'h0, 24'(ser_err[1]));
    wr(A_DIAG, 2, 24'h0001);
    chk("diag_en", 24'h1, 24'(diag_en[1]));
    wr(A_GAIN, 3, 24'h123456);
    gain_upset = 1'b1;
    @(negedge ref_clk);
    gain_upset = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("reg_err rev0", 24'h1, 24'(reg_err[0]));
    chk("reg_err rev1", 24'h0, 24'(reg_err[1]));
    wr(A_DIAG, 2, 24'h0002);
    chk("diag_en", 24'h2, 24'(diag_en[1]));
    sdc_host_inst.frame(8'h80, 0, 24'h0, 0, r);
    chk("ser_err on", 24'h1, 24'(ser_err[1]));
  endtask

  // Watchdog well past the expected run length
  initial begin
    repeat (80000) @(posedge ref_clk);
    failures++;
    results;
  end

  // Main sequence
  initial begin
    rstn = 1'b0;
    sel = 1'b1;
    gain_upset = 1'b0;
    adc_in = 24'h0;
    repeat (8) @(negedge ref_clk);
    rstn = 1'b1;
    t_reset;
    t_power;
    t_filter;
    t_coding;
    t_single;
    t_rev;
    t_diag;
    results;
  end
endmodule // sdc_ctrl_test
